// [include/rtpit_pkg.sv]
// Constants for the remote terminal table base and pending interrupt block.
// Assumes a 16-bit host register port and one 40 MHz clock.
// Contract
// - The table base register reads 0x0200 after master reset or software reset.
// - Bit 15 and bits 8:0 of the table base register are always zero and cannot be written.
// - The table base value is the start address of the active descriptor table, and a write switches tables.
// - An enabled event sets its pending bit, raises the matching interrupt output and makes a log entry.
// - A disabled event sets no pending bit, raises no output and makes no log entry.
// - Each host read of the pending register clears every bit that an event in the same cycle does not set again.
// - Master reset clears the pending register and software reset leaves it alone.
// - Pending bit 15 and the message interrupt follow an index-zero event only when enabled and allowed by the control word.
// - Pending bit 14 and the message interrupt follow each legal message when enabled and allowed by the control word.
// - Pending bit 13 and the message interrupt follow each legal broadcast when enabled and allowed by the control word.
// - Pending bit 10 and the message interrupt follow each enabled message error.
// - Pending bit 8 and the message interrupt follow each enabled illegal command.
package rtpit_pkg;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 16;
	// Register offsets
	localparam logic [15:0] OFF_TABLE_BASE = 16'h0005;
	localparam logic [15:0] OFF_PENDING = 16'h0006;
	// Reset values
	localparam logic [15:0] BASE_RESET = 16'h0200;
	localparam logic [15:0] PEND_RESET = 16'h0000;
	localparam logic [15:0] READ_ZERO = 16'h0000;
	// Writable bits of the table base: 14:9
	localparam logic [15:0] BASE_KEEP = 16'h7e00;
	// Pending bit positions
	localparam int BIT_INDEX_ZERO = 15;
	localparam int BIT_ACCESSED = 14;
	localparam int BIT_BROADCAST = 13;
	localparam int BIT_MSG_ERROR = 10;
	localparam int BIT_ILLEGAL_CMD = 8;
	// Bits this block can set; message type and hardware type groups
	localparam logic [15:0] PEND_IMPL = 16'he500;
	localparam logic [15:0] MSG_MASK = 16'he500;
	localparam logic [15:0] HW_MASK = 16'h00ff;

	// Strip the forced-zero bits of a table base value
	function automatic logic [15:0] base_clean(input logic [15:0] value);
		base_clean = value & BASE_KEEP;
	endfunction
endpackage

// [include/rtpit_evt_if.sv]
// Event carrier between the register core and the pending unit.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface rtpit_evt_if;
	logic [15:0] raw;
	logic [15:0] enable;
	logic rd_clear;
	logic [15:0] pend;
	logic [15:0] pend_next;
	logic log_valid;
	logic [15:0] log_bits;
	logic msg_irq;
	logic hw_irq;

	// Core side: supplies events, enables and the read strobe
	modport core (
		output raw,
		output enable,
		output rd_clear,
		input pend,
		input pend_next,
		input log_valid,
		input log_bits,
		input msg_irq,
		input hw_irq
	);
	// Pending side: holds the sticky bits and the outputs
	modport unit (
		input raw,
		input enable,
		input rd_clear,
		output pend,
		output pend_next,
		output log_valid,
		output log_bits,
		output msg_irq,
		output hw_irq
	);
endinterface
`default_nettype wire

// [rtl/rtpit_pending.sv]
// Pending interrupt register, interrupt outputs and log event strobe.
// Assumes events are one-cycle pulses already gated by the control word.
`timescale 1ns/100ps
`default_nettype none
module rtpit_pending (
	// Clock and master reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Event carrier
	rtpit_evt_if.unit evt
);
	logic [15:0] set_bits;
	logic [15:0] pend_reg;
	logic [15:0] pend_next;

	assign set_bits = evt.raw & evt.enable & rtpit_pkg::PEND_IMPL;

	always_comb begin
		pend_next = evt.rd_clear ? rtpit_pkg::PEND_RESET : pend_reg;
		pend_next = pend_next | set_bits;
	end

	// only master reset and a pending read clear the sticky bits
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_reg <= rtpit_pkg::PEND_RESET;
		end else begin
			pend_reg <= pend_next;
		end
	end

	// interrupt outputs are levels held while a bit of their type is pending
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			evt.msg_irq <= 1'b0;
			evt.hw_irq <= 1'b0;
		end else begin
			evt.msg_irq <= |(pend_next & rtpit_pkg::MSG_MASK);
			evt.hw_irq <= |(pend_next & rtpit_pkg::HW_MASK);
		end
	end

	// one log strobe per cycle, all simultaneous events in one entry
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			evt.log_valid <= 1'b0;
			evt.log_bits <= rtpit_pkg::PEND_RESET;
		end else begin
			evt.log_valid <= |set_bits;
			evt.log_bits <= set_bits;
		end
	end

	assign evt.pend = pend_reg;
	assign evt.pend_next = pend_next;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	AST_SET_WINS: assert property (evt.rd_clear && (set_bits != 16'h0000) |=> ((pend_reg & $past(set_bits)) == $past(set_bits)))
		else $error("event lost to read clear");
endmodule // rtpit_pending
`default_nettype wire

// [rtl/rtpit_top.sv]
// Descriptor table base register and pending interrupt register of a remote terminal.
// Assumes a synchronous host register port with one-cycle read and write strobes,
// and terminal events as one-cycle pulses on mclk.
`timescale 1ns/100ps
`default_nettype none
module rtpit_top (
	// Clock and resets
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic software_reset_request,
	// Host register port
	input wire logic [rtpit_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [rtpit_pkg::DATA_W-1:0] reg_wdata,
	output logic [rtpit_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	// Interrupt enables, same bit layout as the pending register
	input wire logic [15:0] irq_enable,
	// Subaddress control word permissions
	input wire logic cw_allow_index_zero,
	input wire logic cw_allow_accessed,
	input wire logic cw_allow_broadcast,
	// Terminal events
	input wire logic index_zero_irq,
	input wire logic accessed_irq,
	input wire logic broadcast_rx_irq,
	input wire logic message_error_irq,
	input wire logic illegal_command_irq,
	// Descriptor table
	output logic [15:0] table_base_out,
	output logic table_switch,
	// Interrupt outputs and log strobe
	output logic message_irq_out,
	output logic hardware_irq_out,
	output logic log_valid,
	output logic [15:0] log_bits
);
	logic [15:0] base_reg;
	logic table_switch_reg;
	logic [15:0] rdata_reg;
	logic rvalid_reg;
	logic base_wr;
	logic pend_rd;
	logic base_rd;

	rtpit_evt_if evt ();

	// Register decode
	assign base_wr = reg_wr && (reg_addr == rtpit_pkg::OFF_TABLE_BASE);
	assign base_rd = reg_rd && (reg_addr == rtpit_pkg::OFF_TABLE_BASE);
	// a write at the pending offset matches nothing and is dropped
	assign pend_rd = reg_rd && (reg_addr == rtpit_pkg::OFF_PENDING);

	// table base register
	// Software reset wins over a write in the same cycle, so the table is known afterwards.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			base_reg <= rtpit_pkg::BASE_RESET;
		end else if (software_reset_request) begin
			base_reg <= rtpit_pkg::BASE_RESET;
		end else if (base_wr) begin
			base_reg <= rtpit_pkg::base_clean(reg_wdata);
		end
	end

	// table switch strobe
	// Raised for both a write and a software reset; the core reloads the table either way.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			table_switch_reg <= 1'b0;
		end else begin
			table_switch_reg <= base_wr || software_reset_request;
		end
	end

	always_comb begin
		evt.raw = 16'h0000;
		evt.raw[rtpit_pkg::BIT_INDEX_ZERO] = index_zero_irq && cw_allow_index_zero;
		evt.raw[rtpit_pkg::BIT_ACCESSED] = accessed_irq && cw_allow_accessed;
		evt.raw[rtpit_pkg::BIT_BROADCAST] = broadcast_rx_irq && cw_allow_broadcast;
		evt.raw[rtpit_pkg::BIT_MSG_ERROR] = message_error_irq;
		evt.raw[rtpit_pkg::BIT_ILLEGAL_CMD] = illegal_command_irq;
	end

	assign evt.enable = irq_enable;
	// read of the pending register clears it
	assign evt.rd_clear = pend_rd;

	// Pending bits, interrupt outputs and log strobe
	rtpit_pending u_pending (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.evt(evt)
	);

	// Read data, one cycle after the strobe
	// forced-zero bits are zero in the stored value itself
	// Unmapped offsets answer zero so the host never waits.
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg <= rtpit_pkg::READ_ZERO;
		end else if (base_rd) begin
			rdata_reg <= base_reg;
		end else if (pend_rd) begin
			rdata_reg <= evt.pend;
		end else if (reg_rd) begin
			rdata_reg <= rtpit_pkg::READ_ZERO;
		end
	end

	// Read valid strobe
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_rd;
		end
	end

	// Output wiring, all from flip-flops
	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
	assign table_base_out = base_reg;
	assign table_switch = table_switch_reg;
	assign message_irq_out = evt.msg_irq;
	assign hardware_irq_out = evt.hw_irq;
	assign log_valid = evt.log_valid;
	assign log_bits = evt.log_bits;

	// Checks on the design's own outputs
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence s_base_write;
		base_wr && !software_reset_request;
	endsequence

	sequence s_pend_read_quiet;
		pend_rd && ((evt.raw & irq_enable & rtpit_pkg::PEND_IMPL) == 16'h0000);
	endsequence

	sequence s_index_zero_go;
		index_zero_irq && irq_enable[rtpit_pkg::BIT_INDEX_ZERO] && cw_allow_index_zero;
	endsequence

	sequence s_msg_seen(int bitpos);
		log_valid && log_bits[bitpos] && evt.pend[bitpos] && message_irq_out;
	endsequence

	AST_BASE_SWRST: assert property (software_reset_request |=> (table_base_out == 16'h0200) && table_switch)
		else $error("table base not reloaded by software reset");

	AST_BASE_ZERO_BITS: assert property ((table_base_out & 16'h81ff) == 16'h0000)
		else $error("table base forced-zero bit set");

	// write becomes the active table base, readable afterwards
	AST_BASE_WRITE: assert property (s_base_write |=> (table_base_out == ($past(reg_wdata) & 16'h7e00)) && table_switch)
		else $error("table base write not taken");

	AST_BASE_READBACK: assert property (base_rd |=> reg_rvalid && (reg_rdata == $past(table_base_out)))
		else $error("table base read value wrong");

	AST_DISABLED_QUIET: assert property (s_pend_read_quiet |=> (evt.pend == 16'h0000) && !log_valid)
		else $error("disabled event acted");

	// read returns old value and clears
	// The interrupt level drops on the same edge as the answer; a later event may raise it again.
	AST_READ_CLEAR: assert property (s_pend_read_quiet |=> reg_rvalid && (reg_rdata == $past(evt.pend)) && !message_irq_out)
		else $error("pending read did not clear");

	// read answer comes exactly one cycle after the strobe
	AST_RVALID_ONE: assert property (reg_rvalid == $past(reg_rd))
		else $error("read valid not one cycle after strobe");

	AST_SWRST_KEEPS: assert property (software_reset_request && !pend_rd |=> ((evt.pend & $past(evt.pend)) == $past(evt.pend)))
		else $error("software reset disturbed pending bits");

	// index zero gated by enable and control word
	AST_INDEX_ZERO_SET: assert property (s_index_zero_go |=> s_msg_seen(rtpit_pkg::BIT_INDEX_ZERO))
		else $error("index zero event not reported");

	AST_INDEX_ZERO_BLOCK: assert property (index_zero_irq && !cw_allow_index_zero |=> !(log_valid && log_bits[rtpit_pkg::BIT_INDEX_ZERO]))
		else $error("index zero reported without permission");

	AST_ACCESSED_SET: assert property (accessed_irq && cw_allow_accessed && irq_enable[rtpit_pkg::BIT_ACCESSED] |=> s_msg_seen(rtpit_pkg::BIT_ACCESSED))
		else $error("accessed event not reported");

	AST_BROADCAST_SET: assert property (broadcast_rx_irq && cw_allow_broadcast && irq_enable[rtpit_pkg::BIT_BROADCAST] |=> s_msg_seen(rtpit_pkg::BIT_BROADCAST))
		else $error("broadcast event not reported");

	AST_MSG_ERROR_SET: assert property (message_error_irq && irq_enable[rtpit_pkg::BIT_MSG_ERROR] |=> s_msg_seen(rtpit_pkg::BIT_MSG_ERROR))
		else $error("message error not reported");

	AST_ILLEGAL_CMD_SET: assert property (illegal_command_irq && irq_enable[rtpit_pkg::BIT_ILLEGAL_CMD] |=> s_msg_seen(rtpit_pkg::BIT_ILLEGAL_CMD))
		else $error("illegal command not reported");

	// a write at the pending offset leaves the bits alone
	AST_PEND_WRITE_IGNORED: assert property (reg_wr && !reg_rd && (reg_addr == rtpit_pkg::OFF_PENDING) && ((evt.raw & irq_enable & rtpit_pkg::PEND_IMPL) == 16'h0000) |=> (evt.pend == $past(evt.pend)))
		else $error("pending register took a write");

	// message interrupt level tracks the pending message bits
	AST_IRQ_FOLLOWS_PEND: assert property (message_irq_out == ((evt.pend & rtpit_pkg::MSG_MASK) != 16'h0000))
		else $error("message interrupt out of step with pending bits");

	// no hardware type event lives in this block
	AST_HW_QUIET: assert property (!hardware_irq_out)
		else $error("hardware interrupt raised");

	// no table switch without a write or software reset
	AST_SWITCH_QUIET: assert property (!base_wr && !software_reset_request |=> !table_switch)
		else $error("spurious table switch");

	AST_UNUSED_ZERO: assert property ((evt.pend & 16'h1a00) == 16'h0000)
		else $error("unused pending bit set");

	// disabled message error makes no log entry
	AST_MSG_ERROR_MASKED: assert property (message_error_irq && !irq_enable[rtpit_pkg::BIT_MSG_ERROR] |=> !log_bits[rtpit_pkg::BIT_MSG_ERROR])
		else $error("masked message error logged");
endmodule // rtpit_top
`default_nettype wire

// [sim/rtpit_host.sv]
// Host processor model: drives the register strobes of the block.
// Assumes calls come just after a falling edge of mclk.
`timescale 1ns/100ps
`default_nettype none
module rtpit_host (
	// Register bus toward the block
	output logic [15:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata
);
	// Quiet bus at time zero
	initial begin
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end

	// Idle calls flip released lines so a stale word never looks live
	task automatic req(input logic wr, input logic rd, input logic [15:0] ad,
		input logic [15:0] wd);
		reg_wr = wr;
		reg_rd = rd;
		reg_addr = (wr || rd) ? ad : ~reg_addr;
		reg_wdata = (wr || rd) ? wd : ~reg_wdata;
	endtask
endmodule // rtpit_host
`default_nettype wire

// [sim/rt_pending_irq_and_table_base_tb.sv]
// Self-checking bench for the table base and pending interrupt block.
// Assumes the host model owns the bus; all inputs move on falling edges.
`timescale 1ns/100ps
`default_nettype none
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %h got %h", w, e, g); end end
module rt_pending_irq_and_table_base_tb;
	logic mclk, sys_rst, software_reset_request, reg_wr, reg_rd, reg_rvalid;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, irq_enable, table_base_out, log_bits;
	logic cw_allow_index_zero, cw_allow_accessed, cw_allow_broadcast, index_zero_irq, accessed_irq;
	logic broadcast_rx_irq, message_error_irq, illegal_command_irq;
	logic table_switch, message_irq_out, hardware_irq_out, log_valid;
	int n_fail, n_compared, base_m, pend_m;

	rtpit_host host_u (.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata));
	rtpit_top dut_u (.mclk(mclk), .sys_rst(sys_rst),
		.software_reset_request(software_reset_request), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .irq_enable(irq_enable),
		.cw_allow_index_zero(cw_allow_index_zero),
		.cw_allow_accessed(cw_allow_accessed), .cw_allow_broadcast(cw_allow_broadcast),
		.index_zero_irq(index_zero_irq), .accessed_irq(accessed_irq),
		.broadcast_rx_irq(broadcast_rx_irq), .message_error_irq(message_error_irq),
		.illegal_command_irq(illegal_command_irq), .table_base_out(table_base_out),
		.table_switch(table_switch), .message_irq_out(message_irq_out),
		.hardware_irq_out(hardware_irq_out), .log_valid(log_valid), .log_bits(log_bits));

	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Verdict and end of run
	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Levels that follow the model in every cycle
	task automatic chk_state();
		`CHK("table_base_out", 16'(base_m), table_base_out)
		`CHK("message_irq_out", pend_m != 0, message_irq_out)
		`CHK("hardware_irq_out", 1'b0, hardware_irq_out)
	endtask

	// One cycle of bus request, software reset and events, then all results checked
	task automatic step(input logic wr, input logic rd, input logic [15:0] ad,
		input logic [15:0] wd, input logic sr, input logic [4:0] e, input logic [2:0] a);
		logic [15:0] nb;
		int exp_rd;
		software_reset_request = sr;
		{index_zero_irq, accessed_irq, broadcast_rx_irq, message_error_irq,
			illegal_command_irq} = e;
		{cw_allow_index_zero, cw_allow_accessed, cw_allow_broadcast} = a;
		host_u.req(wr, rd, ad, wd);
		nb = 16'h0000;
		nb[15] = e[4] & a[2] & irq_enable[15];
		nb[14] = e[3] & a[1] & irq_enable[14];
		nb[13] = e[2] & a[0] & irq_enable[13];
		nb[10] = e[1] & irq_enable[10];
		nb[8] = e[0] & irq_enable[8];
		exp_rd = (ad == 16'h0005) ? base_m : (ad == 16'h0006) ? pend_m : 0;
		@(negedge mclk);
		// software reset wins over a base write
		if (sr) base_m = 32'h0200;
		else if (wr && ad == 16'h0005) base_m = int'(wd & 16'h7e00);
		// a read clears older bits, a same-cycle event survives
		if (rd && ad == 16'h0006) pend_m = 0;
		pend_m = pend_m | int'(nb);
		`CHK("log_valid", nb != 16'h0000, log_valid)
		if (nb != 16'h0000) `CHK("log_bits", nb, log_bits)
		`CHK("reg_rvalid", rd, reg_rvalid)
		if (rd) `CHK("reg_rdata", 16'(exp_rd), reg_rdata)
		`CHK("table_switch", sr || (wr && ad == 16'h0005), table_switch)
		chk_state();
	endtask

	// Plain register accesses with no events
	task automatic rd_reg(input logic [15:0] ad);
		step(1'b0, 1'b1, ad, 16'h0000, 1'b0, 5'h00, 3'h0);
	endtask
	task automatic wr_reg(input logic [15:0] ad, input logic [15:0] wd);
		step(1'b1, 1'b0, ad, wd, 1'b0, 5'h00, 3'h0);
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		close_out();
	end

	// Main sequence
	initial begin
		int op;
		n_fail = 0;
		n_compared = 0;
		base_m = 32'h0200;
		pend_m = 0;
		sys_rst = 1'b1;
		software_reset_request = 1'b0;
		irq_enable = 16'h0000;
		{cw_allow_index_zero, cw_allow_accessed, cw_allow_broadcast} = 3'h0;
		{index_zero_irq, accessed_irq, broadcast_rx_irq, message_error_irq,
			illegal_command_irq} = 5'h00;
		void'($urandom(84));
		repeat (4) @(negedge mclk);
		sys_rst = 1'b0;
		rd_reg(16'h0005);
		rd_reg(16'h0006);
		// forced-zero bits, all ones and then only the forced-zero bits set
		wr_reg(16'h0005, 16'hffff);
		rd_reg(16'h0005);
		wr_reg(16'h0005, 16'h81ff);
		rd_reg(16'h0005);
		// pending register ignores writes; unmapped place reads zero
		wr_reg(16'h0006, 16'hffff);
		rd_reg(16'h0006);
		wr_reg(16'h0009, 16'h1234);
		rd_reg(16'h0009);
		// software reset keeps pending bits while the base reloads
		irq_enable = 16'hffff;
		step(1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, 5'h1f, 3'h7);
		step(1'b0, 1'b0, 16'h0000, 16'h0000, 1'b1, 5'h00, 3'h0);
		rd_reg(16'h0005);
		rd_reg(16'h0006);
		// random traffic; base writes stay at multiples of 0x0200
		for (int i = 0; i < 400; i++) begin
			op = $urandom_range(3);
			irq_enable = 16'($urandom);
			step(op == 1, op == 0 || op == 2, (op == 0) ? 16'h0006 : 16'h0005,
				(16'($urandom) & 16'h7e00) | 16'h0200, 1'b0, 5'($urandom), 3'($urandom));
		end
		// master reset mid-run drops pending bits and restores the base
		irq_enable = 16'hffff;
		step(1'b0, 1'b0, 16'h0000, 16'h0000, 1'b0, 5'h02, 3'h0);
		sys_rst = 1'b1;
		base_m = 32'h0200;
		pend_m = 0;
		@(negedge mclk);
		chk_state();
		sys_rst = 1'b0;
		rd_reg(16'h0006);
		close_out();
	end
endmodule // rt_pending_irq_and_table_base_tb
`undef CHK
`default_nettype wire
